//--- src/status_bank3_defs.svh
// Constants for the bank-3 special-function register block.
// Assumes APB byte address = 4 * register index, data in bits 7:0.
`ifndef STATUS_BANK3_DEFS_SVH
`define STATUS_BANK3_DEFS_SVH

// ==========================================================
// Register indices
`define REG_INDIRECT 9'h180
`define REG_OPTION 9'h181
`define REG_PC_LOW 9'h182
`define REG_STATUS 9'h183
`define REG_POINTER 9'h184
`define REG_TRIS_B 9'h186
`define REG_TRIS_F 9'h187
`define REG_TRIS_G 9'h188
`define REG_PC_LATCH 9'h18A
`define REG_INT_CTRL 9'h18B
`define WINDOW_LAST 9'h19F
`define WINDOW_TAG 4'hC

// ==========================================================
// Reset values and masks
`define RST_ONES 8'hFF
`define RST_ZERO 8'h00
`define RST_STATUS 8'h18
`define PC_LATCH_MASK 8'h1F
`define STATUS_SW_MASK 8'hE7
`define STATUS_FLAG_MASK 8'h07
`define STATUS_ZERO_BIT 8'h04

`endif

//--- src/status_bank3_pkg.sv
// Types for the bank-3 special-function register block.
// Assumes the core issues at most one instruction per clock.
package status_bank3_pkg;

	// ==========================================================
	// Instruction kinds the block executes itself
	typedef enum logic [2:0] {
		op_add,
		op_sub,
		op_clr,
		op_bit_clear,
		op_bit_set,
		op_swap,
		op_move_w
	} exec_op_type;

	// ==========================================================
	// Request groups
	typedef struct packed {
		logic valid;
		exec_op_type op;
		logic [4:0] offset;
		logic to_file;
		logic [7:0] w;
		logic [2:0] bit_sel;
	} exec_req_type;

	typedef struct packed {
		logic watchdog_timeout;
		logic watchdog_clear;
		logic sleep;
	} device_event_type;

	typedef struct packed {
		logic valid;
		logic timeout;
		logic powerdown;
	} core_reset_type;

endpackage : status_bank3_pkg

//--- src/status_bank3.sv
// Bank-3 special-function registers with the status register and a small ALU.
// Assumes an APB master, and a core whose requests and events are on pclk.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "status_bank3_defs.svh"

module status_bank3 #(
	parameter int MEM_DEPTH = 512
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire status_bank3_pkg::exec_req_type exec_req,
	input wire status_bank3_pkg::device_event_type events,
	input wire status_bank3_pkg::core_reset_type core_reset,
	output logic [7:0] w_result,
	output logic [7:0] status_out,
	output logic indirect_bank,
	output logic [1:0] direct_bank
);

	// ==========================================================
	// State
	logic [7:0] option_q, option_d;
	logic [7:0] pcl_q, pcl_d;
	logic [7:0] status_q, status_d;
	logic [7:0] pointer_q, pointer_d;
	logic [7:0] tris_q [0:2];
	logic [7:0] tris_d [0:2];
	logic [7:0] program_counter_high_latch_q, program_counter_high_latch_d;
	logic [7:0] interrupt_control_q, interrupt_control_d;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;
	logic pready_q, pready_d;
	logic [7:0] w_result_q, w_result_d;
	// Plain RAM stands behind every pointer target outside this window.
	logic [7:0] mem [0:MEM_DEPTH-1];
	logic mem_we;
	logic [8:0] mem_addr;
	logic [7:0] mem_wdata;

	// ==========================================================
	// Decode helpers
	function automatic logic in_window(input logic [8:0] idx);
		in_window = (idx[8:5] == `WINDOW_TAG);
	endfunction : in_window

	// Pointer target uses bit 7 of status as the ninth address bit.
	function automatic logic [8:0] resolve(input logic [8:0] idx);
		resolve = (idx == `REG_INDIRECT) ? {status_q[7], pointer_q} : idx;
	endfunction : resolve

	function automatic logic [7:0] read_sfr(input logic [8:0] idx);
		unique case (idx)
			`REG_OPTION: read_sfr = option_q;
			`REG_PC_LOW: read_sfr = pcl_q;
			`REG_STATUS: read_sfr = status_q;
			`REG_POINTER: read_sfr = pointer_q;
			`REG_TRIS_B: read_sfr = tris_q[0];
			`REG_TRIS_F: read_sfr = tris_q[1];
			`REG_TRIS_G: read_sfr = tris_q[2];
			`REG_PC_LATCH: read_sfr = program_counter_high_latch_q & `PC_LATCH_MASK;
			`REG_INT_CTRL: read_sfr = interrupt_control_q;
			default: read_sfr = `RST_ZERO;
		endcase
	endfunction : read_sfr

	function automatic logic [7:0] read_any(input logic [8:0] idx);
		logic [8:0] t;
		t = resolve(idx);
		read_any = in_window(t) ? read_sfr(t) : mem[t[$clog2(MEM_DEPTH)-1:0]];
	endfunction : read_any

	// ==========================================================
	// APB decode
	logic [8:0] apb_idx;
	logic apb_mapped;
	logic apb_setup;
	logic apb_write;
	assign apb_idx = paddr[10:2];
	assign apb_mapped = !paddr[11] && paddr[1:0] == 2'h0 && in_window(apb_idx);
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite && pready_q && !pslverr_q && pstrb[0];

	// ==========================================================
	// ALU
	logic [8:0] exec_idx;
	logic [7:0] f_val;
	logic [7:0] res;
	logic [8:0] wide;
	logic [4:0] nib;
	logic [7:0] flags;
	logic [7:0] flag_mask;
	logic exec_to_file;
	assign exec_idx = {`WINDOW_TAG, exec_req.offset};
	assign f_val = read_any(exec_idx);

	always_comb
	begin
		wide = 9'h000;
		nib = 5'h00;
		res = f_val;
		flag_mask = `RST_ZERO;
		exec_to_file = exec_req.to_file;
		unique case (exec_req.op)
			status_bank3_pkg::op_add:
			begin
				wide = {1'b0, f_val} + {1'b0, exec_req.w};
				nib = {1'b0, f_val[3:0]} + {1'b0, exec_req.w[3:0]};
				flag_mask = `STATUS_FLAG_MASK;
			end
			status_bank3_pkg::op_sub:
			begin
				// Adding the complement leaves carry high when no borrow occurs.
				wide = {1'b0, f_val} + {1'b0, ~exec_req.w} + 9'h001;
				nib = {1'b0, f_val[3:0]} + {1'b0, ~exec_req.w[3:0]} + 5'h01;
				flag_mask = `STATUS_FLAG_MASK;
			end
			status_bank3_pkg::op_clr:
			begin
				flag_mask = `STATUS_ZERO_BIT;
				exec_to_file = 1'b1;
			end
			status_bank3_pkg::op_bit_clear:
			begin
				res = f_val & ~(8'h01 << exec_req.bit_sel);
				exec_to_file = 1'b1;
			end
			status_bank3_pkg::op_bit_set:
			begin
				res = f_val | (8'h01 << exec_req.bit_sel);
				exec_to_file = 1'b1;
			end
			status_bank3_pkg::op_swap: res = {f_val[3:0], f_val[7:4]};
			status_bank3_pkg::op_move_w:
			begin
				res = exec_req.w;
				exec_to_file = 1'b1;
			end
			default: res = f_val;
		endcase
		if (exec_req.op == status_bank3_pkg::op_add || exec_req.op == status_bank3_pkg::op_sub)
		begin
			res = wide[7:0];
		end
		if (exec_req.op == status_bank3_pkg::op_clr)
		begin
			res = `RST_ZERO;
		end
		flags = {5'h00, res == 8'h00, nib[4], wide[8]};
	end

	// ==========================================================
	// Next state for the registers
	logic [8:0] tgt;
	logic [7:0] wmask;
	logic port_we [0:1];
	logic [8:0] port_idx [0:1];
	logic [7:0] port_data [0:1];

	always_comb
	begin
		tgt = 9'h000;
		wmask = `RST_ZERO;
		option_d = option_q;
		pcl_d = pcl_q;
		status_d = status_q;
		pointer_d = pointer_q;
		tris_d = tris_q;
		program_counter_high_latch_d = program_counter_high_latch_q;
		interrupt_control_d = interrupt_control_q;
		w_result_d = w_result_q;
		mem_we = 1'b0;
		mem_addr = 9'h000;
		mem_wdata = `RST_ZERO;
		port_we[0] = apb_write;
		port_idx[0] = apb_idx;
		port_data[0] = pwdata[7:0];
		port_we[1] = exec_req.valid && exec_to_file;
		port_idx[1] = exec_idx;
		port_data[1] = res;
		// Device events and the core reset are the only paths into the cause bits.
		if (events.watchdog_clear || events.sleep)
		begin
			status_d[4] = 1'b1;
			status_d[3] = events.watchdog_clear;
		end
		if (events.watchdog_timeout)
		begin
			status_d[4] = 1'b0;
		end
		// Port 1 runs last so the core wins over a bus write in the same cycle.
		for (int p = 0; p < 2; p++)
		begin
			if (port_we[p])
			begin
				tgt = resolve(port_idx[p]);
				wmask = `STATUS_SW_MASK;
				if (p == 1 && flag_mask != `RST_ZERO)
				begin
					wmask = `STATUS_SW_MASK & ~`STATUS_FLAG_MASK;
				end
				if (!in_window(tgt))
				begin
					mem_we = 1'b1;
					mem_addr = tgt;
					mem_wdata = port_data[p];
				end
				unique case (tgt)
					`REG_OPTION: option_d = port_data[p];
					`REG_PC_LOW: pcl_d = port_data[p];
					`REG_STATUS: status_d = (status_d & ~wmask) | (port_data[p] & wmask);
					`REG_POINTER: pointer_d = port_data[p];
					`REG_TRIS_B: tris_d[0] = port_data[p];
					`REG_TRIS_F: tris_d[1] = port_data[p];
					`REG_TRIS_G: tris_d[2] = port_data[p];
					`REG_PC_LATCH: program_counter_high_latch_d = port_data[p] & `PC_LATCH_MASK;
					`REG_INT_CTRL: interrupt_control_d = port_data[p];
					default: wmask = wmask;
				endcase
			end
		end
		if (exec_req.valid)
		begin
			status_d = (status_d & ~flag_mask) | (flags & flag_mask);
			if (!exec_to_file)
			begin
				w_result_d = res;
			end
		end
		if (core_reset.valid)
		begin
			status_d = {3'b000, core_reset.timeout, core_reset.powerdown, status_q[2:0]};
			option_d = `RST_ONES;
			pcl_d = `RST_ZERO;
			tris_d = '{`RST_ONES, `RST_ONES, `RST_ONES};
			program_counter_high_latch_d = `RST_ZERO;
			interrupt_control_d = {7'h00, interrupt_control_q[0]};
			mem_we = 1'b0;
		end
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		pready_d = 1'b1;
		if (apb_setup)
		begin
			prdata_d = {24'h000000, apb_mapped ? read_any(apb_idx) : `RST_ZERO};
			pslverr_d = !apb_mapped;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			option_q <= `RST_ONES;
			pcl_q <= `RST_ZERO;
			status_q <= `RST_STATUS;
			pointer_q <= `RST_ZERO;
			tris_q <= '{`RST_ONES, `RST_ONES, `RST_ONES};
			program_counter_high_latch_q <= `RST_ZERO;
			interrupt_control_q <= `RST_ZERO;
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
			pready_q <= 1'b0;
			w_result_q <= `RST_ZERO;
		end
		else
		begin
			option_q <= option_d;
			pcl_q <= pcl_d;
			status_q <= status_d;
			pointer_q <= pointer_d;
			tris_q <= tris_d;
			program_counter_high_latch_q <= program_counter_high_latch_d;
			interrupt_control_q <= interrupt_control_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
			pready_q <= pready_d;
			w_result_q <= w_result_d;
		end
	end

	// RAM has no reset; software must write a byte before reading it back.
	always_ff @(posedge pclk)
	begin
		if (mem_we)
		begin
			mem[mem_addr[$clog2(MEM_DEPTH)-1:0]] <= mem_wdata;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign w_result = w_result_q;
	assign status_out = status_q;
	assign indirect_bank = status_q[7];
	assign direct_bank = status_q[6:5];

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic quiet;
	assign quiet = !core_reset.valid && events == 3'b000;

	property p_cause_protected;
		apb_write && apb_idx == `REG_STATUS && !exec_req.valid && quiet |=> status_q[4:3] == $past(status_q[4:3]);
	endproperty
	a_cause_protected: assert property (p_cause_protected) else $error("cause bits took a bus write");

	property p_clear_status;
		exec_req.valid && exec_req.op == status_bank3_pkg::op_clr && exec_idx == `REG_STATUS && quiet
		|=> status_q[7:5] == 3'b000 && status_q[2] && status_q[4:3] == $past(status_q[4:3])
		&& status_q[1:0] == $past(status_q[1:0]);
	endproperty
	a_clear_status: assert property (p_clear_status) else $error("clear of status gave a wrong value");

	property p_sub_borrow;
		exec_req.valid && exec_req.op == status_bank3_pkg::op_sub && !core_reset.valid
		|=> status_q[0] == ($past(f_val) >= $past(exec_req.w));
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("carry is not the inverted borrow");

	property p_add_carry;
		exec_req.valid && exec_req.op == status_bank3_pkg::op_add && !core_reset.valid
		|=> status_q[0] == (({1'b0, $past(f_val)} + {1'b0, $past(exec_req.w)}) > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry out of bit 7 is wrong");

	property p_unimplemented_zero;
		apb_setup && apb_mapped && apb_idx > `REG_INT_CTRL |=> prdata_q == 32'h00000000 && !pslverr_q;
	endproperty
	a_unimplemented_zero: assert property (p_unimplemented_zero) else $error("unimplemented location read nonzero");

	property p_other_reset;
		core_reset.valid |=> status_q[7:5] == 3'b000 && status_q[4] == $past(core_reset.timeout)
		&& status_q[2:0] == $past(status_q[2:0]) ##1 option_q == `RST_ONES || $past(apb_write);
	endproperty
	a_other_reset: assert property (p_other_reset) else $error("other reset left status wrong");

	property p_timeout_event;
		events.watchdog_timeout && !core_reset.valid |=> !status_q[4] && status_out[4] == status_q[4];
	endproperty
	a_timeout_event: assert property (p_timeout_event) else $error("time-out bit not cleared");

	property p_flags_kept;
		exec_req.valid && exec_req.op inside {status_bank3_pkg::op_bit_clear, status_bank3_pkg::op_bit_set,
		status_bank3_pkg::op_move_w} && exec_idx != `REG_STATUS && !(apb_write && apb_idx == `REG_STATUS)
		&& !core_reset.valid |=> $stable(status_q[2:0]);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("flag changed by a flag-neutral op");

endmodule : status_bank3

//--- verif/status_bank3_tb_top.sv
// Self-checking testbench for the bank-3 status register block.
// Assumes a zero-wait APB slave and exec requests that land at one edge.
`timescale 1ns/100ps
module status_bank3_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, indirect_bank, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] direct_bank;
	logic [7:0] w_result, status_out;
	status_bank3_pkg::exec_req_type exec_req;
	status_bank3_pkg::device_event_type events;
	status_bank3_pkg::core_reset_type core_reset;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;

	status_bank3 DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.exec_req(exec_req), .events(events), .core_reset(core_reset), .w_result(w_result),
		.status_out(status_out), .indirect_bank(indirect_bank), .direct_bank(direct_bank));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// ==========================================================
	// Checks and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_flag(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk_flag

	task automatic stop_test;
		if (bad_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	// A hang anywhere in the sequence ends here instead of running forever.
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			bad_count++;
			stop_test();
		end
	end

	// ==========================================================
	// Drivers
	task automatic apb(input logic is_wr, input logic [8:0] idx, input logic [7:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= is_wr;
		paddr <= {1'b0, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// The write lands at the access edge, so outputs are looked at only once it has settled.
	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
		@(negedge pclk);
	endtask : wr

	task automatic rd_chk(input logic [8:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk(rd, {24'h0, exp});
		chk_flag(err, 1'b0);
	endtask : rd_chk

	task automatic run(input status_bank3_pkg::exec_op_type op, input logic [4:0] off, input logic tf,
		input logic [7:0] w, input logic [2:0] bs);
		@(posedge pclk);
		exec_req <= '{1'b1, op, off, tf, w, bs};
		@(posedge pclk);
		exec_req.valid <= 1'b0;
		@(negedge pclk);
	endtask : run

	// The operand sits in the option register so the status byte only shows flags.
	task automatic alu(input status_bank3_pkg::exec_op_type op, input logic [7:0] f, input logic [7:0] w,
		input logic [7:0] res, input logic [7:0] st);
		wr(9'h181, f);
		run(op, 5'h01, 1'b0, w, 3'h0);
		chk(w_result, res);
		chk(status_out, st);
	endtask : alu

	task automatic pulse(input logic [2:0] ev);
		@(posedge pclk);
		events <= ev;
		@(posedge pclk);
		events <= 3'h0;
		@(negedge pclk);
	endtask : pulse

	// ==========================================================
	// Sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		exec_req = '0;
		events = '0;
		core_reset = '0;
		repeat (6) @(posedge pclk);
		chk_flag(pready, 1'b0);
		presetn <= 1'b1;
		rd_chk(9'h183, 8'h18);
		rd_chk(9'h181, 8'hFF);
		rd_chk(9'h182, 8'h00);
		rd_chk(9'h184, 8'h00);
		rd_chk(9'h18A, 8'h00);
		for (int i = 6; i < 9; i++)
			rd_chk(9'h180 + 9'(i), 8'hFF);
		for (int i = 5; i < 32; i += 2)
		begin
			if (i != 7 && i != 11)
			begin
				wr(9'h180 + 9'(i), 8'hFF);
				rd_chk(9'h180 + 9'(i), 8'h00);
			end
		end
		wr(9'h18A, 8'hFF);
		rd_chk(9'h18A, 8'h1F);
		apb(1'b1, 9'h1A0, 8'h55);
		chk_flag(err, 1'b1);
		chk(rd, 32'h0);
		wr(9'h181, 8'hA5);
		rd_chk(9'h181, 8'hA5);
		pstrb <= 4'h0;
		wr(9'h181, 8'h00);
		pstrb <= 4'hF;
		rd_chk(9'h181, 8'hA5);
		for (int b = 0; b < 4; b++)
		begin
			wr(9'h183, {1'b1, 2'(b), 5'h00});
			rd_chk(9'h183, {1'b1, 2'(b), 5'h18});
			chk({30'h0, direct_bank}, 32'(b));
			chk_flag(indirect_bank, 1'b1);
		end
		wr(9'h183, 8'h63);
		chk_flag(indirect_bank, 1'b0);
		run(status_bank3_pkg::op_clr, 5'h03, 1'b0, 8'h00, 3'h0);
		chk(status_out, 8'h1F);
		wr(9'h183, 8'h00);
		run(status_bank3_pkg::op_add, 5'h03, 1'b1, 8'hF0, 3'h0);
		chk(status_out, 8'h19);
		run(status_bank3_pkg::op_bit_set, 5'h03, 1'b1, 8'h00, 3'h5);
		chk(status_out, 8'h39);
		run(status_bank3_pkg::op_bit_clear, 5'h03, 1'b1, 8'h00, 3'h0);
		chk(status_out, 8'h38);
		run(status_bank3_pkg::op_swap, 5'h03, 1'b1, 8'h00, 3'h0);
		chk(status_out, 8'h9B);
		run(status_bank3_pkg::op_move_w, 5'h03, 1'b1, 8'h00, 3'h0);
		chk(status_out, 8'h18);
		run(status_bank3_pkg::op_bit_clear, 5'h03, 1'b1, 8'h00, 3'h4);
		chk(status_out, 8'h18);
		alu(status_bank3_pkg::op_add, 8'hF8, 8'h08, 8'h00, 8'h1F);
		alu(status_bank3_pkg::op_add, 8'h01, 8'h02, 8'h03, 8'h18);
		alu(status_bank3_pkg::op_sub, 8'h10, 8'h01, 8'h0F, 8'h19);
		alu(status_bank3_pkg::op_sub, 8'h01, 8'h02, 8'hFF, 8'h18);
		alu(status_bank3_pkg::op_sub, 8'h05, 8'h05, 8'h00, 8'h1F);
		// A bit set on another register must leave every flag as the subtraction left it.
		run(status_bank3_pkg::op_bit_set, 5'h01, 1'b1, 8'h00, 3'h7);
		chk(status_out, 8'h1F);
		rd_chk(9'h181, 8'h85);
		wr(9'h184, 8'h20);
		wr(9'h180, 8'h5A);
		wr(9'h184, 8'h21);
		wr(9'h180, 8'hC3);
		rd_chk(9'h180, 8'hC3);
		wr(9'h184, 8'h20);
		rd_chk(9'h180, 8'h5A);
		pulse(3'h4);
		chk(status_out, 8'h0F);
		wr(9'h183, 8'h18);
		rd_chk(9'h183, 8'h08);
		pulse(3'h2);
		chk(status_out, 8'h18);
		pulse(3'h1);
		chk(status_out, 8'h10);
		wr(9'h183, 8'hE5);
		wr(9'h181, 8'h00);
		@(posedge pclk);
		core_reset <= 3'b101;
		@(posedge pclk);
		core_reset <= 3'b000;
		rd_chk(9'h183, 8'h0D);
		rd_chk(9'h181, 8'hFF);
		rd_chk(9'h184, 8'h20);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(9'h183, 8'h18);
		stop_test();
	end
endmodule : status_bank3_tb_top
